/* hw/cmos_port_block.sv */
// Top of the four-port general-purpose I/O block with its register decode.
// Assumes a CPU special-function bus: one byte or one bit access per strobe.
`default_nettype none

module cmos_port_block (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [15:0] sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_bit_wr,
    input  wire logic [2:0]  sfr_bit_sel,
    input  wire logic [7:0]  sfr_wdata,
    input  wire logic        sfr_rd,
    output logic      [7:0]  sfr_rdata,
    output logic             sfr_hit,
    input  wire logic [7:0]  port0_pin_in,
    output logic      [7:0]  port0_pin_out,
    output logic      [7:0]  port0_pin_oe,
    output logic      [7:0]  port0_pullup_en,
    input  wire logic [5:0]  port1_pin_in,
    output logic      [5:0]  port1_pin_out,
    output logic      [5:0]  port1_pin_oe,
    output logic      [5:0]  port1_pullup_en,
    input  wire logic [7:0]  port2_pin_in,
    output logic      [7:0]  port2_pin_out,
    output logic      [7:0]  port2_pin_oe,
    output logic      [7:0]  port2_pullup_en,
    input  wire logic [1:0]  port3_pin_in,
    output logic      [1:0]  port3_pin_out,
    output logic      [1:0]  port3_pin_oe,
    output logic      [1:0]  port3_pullup_en,
    input  wire logic        timer8_out,
    input  wire logic        timer16_out,
    input  wire logic        buzzer_out,
    output logic      [2:0]  ext_irq_rise,
    output logic      [2:0]  ext_irq_fall,
    output logic             capture_trigger_in,
    output logic             timer8_clock_in
);
    logic [7:0] port_group_pullup;
    logic [7:0] port2_pullup_bits;
    logic [7:0] next_port_group_pullup;
    logic [7:0] next_port2_pullup_bits;
    logic [7:0] next_sfr_rdata;
    logic       next_sfr_hit;

    logic       in_window;
    logic       any_wr;
    logic [3:0] data_we;
    logic [3:0] data_bit_we;
    logic [3:0] dir_we;
    logic [3:0] dir_bit_we;

    logic [7:0] data_rd0, data_rd1, data_rd2, data_rd3;
    logic [7:0] dir_rd0, dir_rd1, dir_rd2, dir_rd3;
    logic [7:0] dir0;
    logic [5:0] dir1;
    logic [7:0] dir2;
    logic [1:0] dir3;
    logic [7:0] alt_out2;
    logic [1:0] alt_out3;

    // Write decode: a byte strobe and a bit strobe each hit one address.
    always_comb begin
        in_window = sfr_addr[15:8] == port_block_pkg::SFR_PAGE;
        any_wr    = sfr_wr | sfr_bit_wr;
        for (int p = 0; p < 4; p++) begin
            data_we[p]     = sfr_wr
                           && sfr_addr == port_block_pkg::ADDR_PORT0_DATA + 16'(p);
            data_bit_we[p] = sfr_bit_wr
                           && sfr_addr == port_block_pkg::ADDR_PORT0_DATA + 16'(p);
            dir_we[p]      = sfr_wr
                           && sfr_addr == port_block_pkg::ADDR_PORT0_DIR + 16'(p);
            dir_bit_we[p]  = sfr_bit_wr
                           && sfr_addr == port_block_pkg::ADDR_PORT0_DIR + 16'(p);
        end
    end

    // The pull-up option registers; pins see their next value so drive and
    // pull-up change on the same edge.
    always_comb begin
        next_port_group_pullup = port_group_pullup;
        next_port2_pullup_bits = port2_pullup_bits;
        if (any_wr && sfr_addr == port_block_pkg::ADDR_GROUP_PULLUP) begin
            if (sfr_wr) begin
                next_port_group_pullup = sfr_wdata & port_block_pkg::GROUP_PULLUP_MASK;
            end else begin
                next_port_group_pullup[sfr_bit_sel] = sfr_wdata[0];
                next_port_group_pullup = next_port_group_pullup
                                       & port_block_pkg::GROUP_PULLUP_MASK;
            end
        end
        if (any_wr && sfr_addr == port_block_pkg::ADDR_PORT2_PULLUP) begin
            if (sfr_wr) begin
                next_port2_pullup_bits = sfr_wdata;
            end else begin
                next_port2_pullup_bits[sfr_bit_sel] = sfr_wdata[0];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            port_group_pullup <= port_block_pkg::PULLUP_RESET;
            port2_pullup_bits <= port_block_pkg::PULLUP_RESET;
        end else begin
            port_group_pullup <= next_port_group_pullup;
            port2_pullup_bits <= next_port2_pullup_bits;
        end
    end

    // Alternate outputs enter through the latch merge; the unused bits are idle.
    always_comb begin
        alt_out2                                  = 8'h00;
        alt_out2[port_block_pkg::TIMER8_PIN]      = timer8_out;
        alt_out3                                  = 2'b00;
        alt_out3[port_block_pkg::TIMER16_PIN]     = timer16_out;
        alt_out3[port_block_pkg::BUZZER_PIN]      = buzzer_out;
    end

    // Only the 8 port 2 pins have their own pull-up control path; ports 0, 1 and 3 each share one group bit.
    port_cell #(.WIDTH(port_block_pkg::PORT0_WIDTH), .PER_BIT_PULLUP(1'b0)) u_port0 (
        .clock       (clock),
        .rst         (rst),
        .data_we     (data_we[0]),
        .data_bit_we (data_bit_we[0]),
        .dir_we      (dir_we[0]),
        .dir_bit_we  (dir_bit_we[0]),
        .bit_sel     (sfr_bit_sel),
        .wdata       (sfr_wdata),
        .pullup_sel  ({8{next_port_group_pullup[port_block_pkg::GROUP_BIT_PORT0]}}),
        .pin_in      (port0_pin_in),
        .alt_out     (8'h00),
        .latch       (),
        .dir         (dir0),
        .pin_out     (port0_pin_out),
        .pin_oe      (port0_pin_oe),
        .pullup_en   (port0_pullup_en),
        .data_rd     (data_rd0),
        .dir_rd      (dir_rd0)
    );

    port_cell #(.WIDTH(port_block_pkg::PORT1_WIDTH), .PER_BIT_PULLUP(1'b0)) u_port1 (
        .clock       (clock),
        .rst         (rst),
        .data_we     (data_we[1]),
        .data_bit_we (data_bit_we[1]),
        .dir_we      (dir_we[1]),
        .dir_bit_we  (dir_bit_we[1]),
        .bit_sel     (sfr_bit_sel),
        .wdata       (sfr_wdata),
        .pullup_sel  ({6{next_port_group_pullup[port_block_pkg::GROUP_BIT_PORT1]}}),
        .pin_in      (port1_pin_in),
        .alt_out     (6'h00),
        .latch       (),
        .dir         (dir1),
        .pin_out     (port1_pin_out),
        .pin_oe      (port1_pin_oe),
        .pullup_en   (port1_pullup_en),
        .data_rd     (data_rd1),
        .dir_rd      (dir_rd1)
    );

    port_cell #(.WIDTH(port_block_pkg::PORT2_WIDTH), .PER_BIT_PULLUP(1'b1)) u_port2 (
        .clock       (clock),
        .rst         (rst),
        .data_we     (data_we[2]),
        .data_bit_we (data_bit_we[2]),
        .dir_we      (dir_we[2]),
        .dir_bit_we  (dir_bit_we[2]),
        .bit_sel     (sfr_bit_sel),
        .wdata       (sfr_wdata),
        .pullup_sel  (next_port2_pullup_bits),
        .pin_in      (port2_pin_in),
        .alt_out     (alt_out2),
        .latch       (),
        .dir         (dir2),
        .pin_out     (port2_pin_out),
        .pin_oe      (port2_pin_oe),
        .pullup_en   (port2_pullup_en),
        .data_rd     (data_rd2),
        .dir_rd      (dir_rd2)
    );

    port_cell #(.WIDTH(port_block_pkg::PORT3_WIDTH), .PER_BIT_PULLUP(1'b0)) u_port3 (
        .clock       (clock),
        .rst         (rst),
        .data_we     (data_we[3]),
        .data_bit_we (data_bit_we[3]),
        .dir_we      (dir_we[3]),
        .dir_bit_we  (dir_bit_we[3]),
        .bit_sel     (sfr_bit_sel),
        .wdata       (sfr_wdata),
        .pullup_sel  ({2{next_port_group_pullup[port_block_pkg::GROUP_BIT_PORT3]}}),
        .pin_in      (port3_pin_in),
        .alt_out     (alt_out3),
        .latch       (),
        .dir         (dir3),
        .pin_out     (port3_pin_out),
        .pin_oe      (port3_pin_oe),
        .pullup_en   (port3_pullup_en),
        .data_rd     (data_rd3),
        .dir_rd      (dir_rd3)
    );

    // The pin level is watched, not the latch, so an output-mode toggle on an
    // interrupt pin raises a request just as an external edge would.
    port_edge_detect #(.WIDTH(port_block_pkg::IRQ_PIN_COUNT)) u_irq_edges (
        .clock  (clock),
        .rst    (rst),
        .pin_in (port2_pin_in[port_block_pkg::IRQ_PIN_FIRST +: port_block_pkg::IRQ_PIN_COUNT]),
        .rise   (ext_irq_rise),
        .fall   (ext_irq_fall)
    );

    // Read mux; an address outside the map reads 00 with sfr_hit low.
    always_comb begin
        next_sfr_hit   = in_window;
        next_sfr_rdata = port_block_pkg::READ_UNMAPPED;
        case (sfr_addr)
            port_block_pkg::ADDR_PORT0_DATA:   next_sfr_rdata = data_rd0;
            port_block_pkg::ADDR_PORT1_DATA:   next_sfr_rdata = data_rd1;
            port_block_pkg::ADDR_PORT2_DATA:   next_sfr_rdata = data_rd2;
            port_block_pkg::ADDR_PORT3_DATA:   next_sfr_rdata = data_rd3;
            port_block_pkg::ADDR_PORT0_DIR:    next_sfr_rdata = dir_rd0;
            port_block_pkg::ADDR_PORT1_DIR:    next_sfr_rdata = dir_rd1;
            port_block_pkg::ADDR_PORT2_DIR:    next_sfr_rdata = dir_rd2;
            port_block_pkg::ADDR_PORT3_DIR:    next_sfr_rdata = dir_rd3;
            port_block_pkg::ADDR_PORT2_PULLUP: next_sfr_rdata = port2_pullup_bits;
            port_block_pkg::ADDR_GROUP_PULLUP: next_sfr_rdata = port_group_pullup;
            default:                           next_sfr_hit   = 1'b0;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            sfr_rdata          <= port_block_pkg::READ_UNMAPPED;
            sfr_hit            <= 1'b0;
            capture_trigger_in <= 1'b0;
            timer8_clock_in    <= 1'b0;
        end else begin
            if (sfr_rd) begin
                sfr_rdata <= next_sfr_rdata;
                sfr_hit   <= next_sfr_hit;
            end
            capture_trigger_in <= port2_pin_in[port_block_pkg::CAPTURE_PIN];
            timer8_clock_in    <= port2_pin_in[port_block_pkg::TIMER8_PIN];
        end
    end

    a_outside_window: assert property (@(posedge clock) disable iff (rst)
        sfr_rd && sfr_addr[15:8] != 8'hff |=> !sfr_hit && sfr_rdata == 8'h00)
        else $error("access outside the window answered");
    a_port2_pullup_write: assert property (@(posedge clock) disable iff (rst)
        sfr_wr && sfr_addr == 16'hff32 |=> port2_pullup_en == $past(sfr_wdata))
        else $error("port 2 pull-up write not applied");
    a_group_write: assert property (@(posedge clock) disable iff (rst)
        sfr_wr && sfr_addr == 16'hfff7
        |=> port0_pullup_en == ({8{$past(sfr_wdata[0])}} & dir0)
            && port3_pullup_en == ({2{$past(sfr_wdata[3])}} & dir3))
        else $error("group pull-up write not applied");
    a_dir1_reads_ones: assert property (@(posedge clock) disable iff (rst)
        sfr_rd && sfr_addr == 16'hff21 |=> sfr_rdata[7:6] == 2'b11 && sfr_hit)
        else $error("unused direction bits did not read as one");
endmodule

`default_nettype wire

/* hw/port_block_pkg.sv */
// Shared constants for the general-purpose port block: register addresses,
// reset values, port widths and the pins that carry alternate functions.
// Assumes an 8-bit special-function-register bus with 16-bit addresses.
`default_nettype none

package port_block_pkg;
    localparam logic [7:0]  SFR_PAGE          = 8'hff;
    localparam logic [15:0] ADDR_PORT0_DATA   = 16'hff00;
    localparam logic [15:0] ADDR_PORT1_DATA   = 16'hff01;
    localparam logic [15:0] ADDR_PORT2_DATA   = 16'hff02;
    localparam logic [15:0] ADDR_PORT3_DATA   = 16'hff03;
    localparam logic [15:0] ADDR_PORT0_DIR    = 16'hff20;
    localparam logic [15:0] ADDR_PORT1_DIR    = 16'hff21;
    localparam logic [15:0] ADDR_PORT2_DIR    = 16'hff22;
    localparam logic [15:0] ADDR_PORT3_DIR    = 16'hff23;
    localparam logic [15:0] ADDR_PORT2_PULLUP = 16'hff32;
    localparam logic [15:0] ADDR_GROUP_PULLUP = 16'hfff7;

    localparam logic [7:0]  DATA_RESET        = 8'h00;
    localparam logic [7:0]  DIR_RESET         = 8'hff;
    localparam logic [7:0]  PULLUP_RESET      = 8'h00;
    localparam logic [7:0]  READ_UNMAPPED     = 8'h00;

    localparam int          PORT0_WIDTH       = 8;
    localparam int          PORT1_WIDTH       = 6;
    localparam int          PORT2_WIDTH       = 8;
    localparam int          PORT3_WIDTH       = 2;

    localparam int          GROUP_BIT_PORT0   = 0;
    localparam int          GROUP_BIT_PORT1   = 1;
    localparam int          GROUP_BIT_PORT3   = 3;
    localparam logic [7:0]  GROUP_PULLUP_MASK = 8'h0b;

    localparam int          IRQ_PIN_FIRST     = 4;
    localparam int          IRQ_PIN_COUNT     = 3;
    localparam int          CAPTURE_PIN       = 6;
    localparam int          TIMER8_PIN        = 7;
    localparam int          TIMER16_PIN       = 0;
    localparam int          BUZZER_PIN        = 1;
endpackage

`default_nettype wire

/* hw/port_cell.sv */
// One port: output latch, per-pin direction, pin drive and pull-up control.
// Assumes pin_in shows the pin's level, synchronous to clock.
`default_nettype none

module port_cell #(
    parameter int WIDTH          = 8,
    parameter bit PER_BIT_PULLUP = 1'b0
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             data_we,
    input  wire logic             data_bit_we,
    input  wire logic             dir_we,
    input  wire logic             dir_bit_we,
    input  wire logic [2:0]       bit_sel,
    input  wire logic [7:0]       wdata,
    input  wire logic [WIDTH-1:0] pullup_sel,
    input  wire logic [WIDTH-1:0] pin_in,
    input  wire logic [WIDTH-1:0] alt_out,
    output logic      [WIDTH-1:0] latch,
    output logic      [WIDTH-1:0] dir,
    output logic      [WIDTH-1:0] pin_out,
    output logic      [WIDTH-1:0] pin_oe,
    output logic      [WIDTH-1:0] pullup_en,
    output logic      [7:0]       data_rd,
    output logic      [7:0]       dir_rd
);
    logic [WIDTH-1:0] next_latch;
    logic [WIDTH-1:0] next_dir;
    logic [WIDTH-1:0] next_pin_out;
    logic [WIDTH-1:0] next_pin_oe;
    logic [WIDTH-1:0] next_pullup_en;

    function automatic logic [WIDTH-1:0] merge(input logic [WIDTH-1:0] old,
                                               input logic byte_we,
                                               input logic bit_we,
                                               input logic [2:0] sel,
                                               input logic [7:0] wd);
        logic [WIDTH-1:0] res;
        res = old;
        if (byte_we) begin
            res = wd[WIDTH-1:0];
        end else if (bit_we) begin
            for (int i = 0; i < WIDTH; i++) begin
                if (sel == 3'(i)) begin
                    res[i] = wd[0];
                end
            end
        end
        return res;
    endfunction

    always_comb begin
        next_latch   = merge(latch, data_we, data_bit_we, bit_sel, wdata);
        next_dir     = merge(dir, dir_we, dir_bit_we, bit_sel, wdata);
        // An alternate output is merged with the latch, so the latch must be 0 for it.
        next_pin_out = next_latch | alt_out;
        next_pin_oe  = ~next_dir;
        if (PER_BIT_PULLUP) begin
            next_pullup_en = pullup_sel;
        end else begin
            next_pullup_en = pullup_sel & next_dir;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            latch     <= port_block_pkg::DATA_RESET[WIDTH-1:0];
            dir       <= port_block_pkg::DIR_RESET[WIDTH-1:0];
            pin_out   <= port_block_pkg::DATA_RESET[WIDTH-1:0];
            pin_oe    <= '0;
            pullup_en <= port_block_pkg::PULLUP_RESET[WIDTH-1:0];
        end else begin
            latch     <= next_latch;
            dir       <= next_dir;
            pin_out   <= next_pin_out;
            pin_oe    <= next_pin_oe;
            pullup_en <= next_pullup_en;
        end
    end

    always_comb begin
        data_rd              = 8'h00;
        data_rd[WIDTH-1:0]   = (latch & ~dir) | (pin_in & dir);
        dir_rd               = 8'hff;
        dir_rd[WIDTH-1:0]    = dir;
    end

    logic [WIDTH-1:0] sel_mask;
    always_comb begin
        sel_mask = '0;
        for (int i = 0; i < WIDTH; i++) begin
            sel_mask[i] = (bit_sel == 3'(i));
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_reset_all_input: assert property ($fell(rst) |-> dir == '1 && pin_oe == '0)
        else $error("direction not all input after reset");
    a_oe_from_dir: assert property (pin_oe == ~dir)
        else $error("output enable disagrees with direction");
    a_bit_write_local: assert property (data_bit_we && !data_we
                                       |=> (latch & ~$past(sel_mask))
                                           == ($past(latch) & ~$past(sel_mask)))
        else $error("bit write disturbed other latch bits");
    a_pullup_input_only: assert property (PER_BIT_PULLUP || (pullup_en & ~dir) == '0)
        else $error("pull-up on an output pin");
endmodule

`default_nettype wire

/* hw/port_edge_detect.sv */
// Level-change detector for the port pins that feed the external interrupt inputs.
// Assumes pin_in is synchronous to clock; valid-edge selection lies downstream.
`default_nettype none

module port_edge_detect #(
    parameter int WIDTH = 3
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);
    logic             armed;
    logic [WIDTH-1:0] prev;
    logic [WIDTH-1:0] next_rise;
    logic [WIDTH-1:0] next_fall;

    // The first sample after reset only primes prev, so no false edge is reported.
    always_comb begin
        next_rise = armed ? (pin_in & ~prev) : '0;
        next_fall = armed ? (~pin_in & prev) : '0;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            armed <= 1'b0;
            prev  <= '0;
            rise  <= '0;
            fall  <= '0;
        end else begin
            armed <= 1'b1;
            prev  <= pin_in;
            rise  <= next_rise;
            fall  <= next_fall;
        end
    end

    a_change_sets_request: assert property (@(posedge clock) disable iff (rst)
        armed && pin_in != prev |=> (rise | fall) != '0)
        else $error("pin level change raised no request");
endmodule

`default_nettype wire

/* bench/port_board.sv */
// Board model for one port: resolves each pin from the block's drive,
// its pull-up and an optional board driver.
// Assumes the block drives pins from registers on the bench clock.
`default_nettype none

module port_board #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] pin_out,
    input  wire logic [W-1:0] pin_oe,
    input  wire logic [W-1:0] pullup_en,
    input  wire logic [W-1:0] ext_en,
    input  wire logic [W-1:0] ext_val,
    output logic      [W-1:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // The block wins over the board here, which hides contention on purpose.
    // A floating pin shows 1 with its pull-up on, else the inverse of pin_out, so a stale level never passes.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                  | (~pin_oe & ~ext_en & (pullup_en | ~pin_out));
endmodule

`default_nettype wire

/* bench/cmos_port_block_tb.sv */
// Self-checking bench for the port block and its register decode.
// Assumes port_board stands on every pin and the register bus is strobed per access.
`default_nettype none

module cmos_port_block_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [15:0] sfr_addr = 16'h0000;
    logic        sfr_wr = 1'b0, sfr_bit_wr = 1'b0, sfr_rd = 1'b0, sfr_hit;
    logic [2:0]  sfr_bit_sel = 3'h0;
    logic [7:0]  sfr_wdata = 8'h00, sfr_rdata;
    logic [7:0]  port0_pin_in, port0_pin_out, port0_pin_oe, port0_pullup_en;
    logic [5:0]  port1_pin_in, port1_pin_out, port1_pin_oe, port1_pullup_en;
    logic [7:0]  port2_pin_in, port2_pin_out, port2_pin_oe, port2_pullup_en;
    logic [1:0]  port3_pin_in, port3_pin_out, port3_pin_oe, port3_pullup_en;
    logic        timer8_out = 1'b0, timer16_out = 1'b0, buzzer_out = 1'b0;
    logic [2:0]  ext_irq_rise, ext_irq_fall;
    logic        capture_trigger_in, timer8_clock_in;
    logic [7:0]  ext0_en = 8'hff, ext0_val = 8'h3c, ext2_en = 8'h00, ext2_val = 8'h00;
    int          bad_count = 0;
    int          checks_done = 0;

    always #2 clock = ~clock;

    cmos_port_block dut (.clock, .rst, .sfr_addr, .sfr_wr, .sfr_bit_wr, .sfr_bit_sel,
        .sfr_wdata, .sfr_rd, .sfr_rdata, .sfr_hit, .port0_pin_in, .port0_pin_out,
        .port0_pin_oe, .port0_pullup_en, .port1_pin_in, .port1_pin_out, .port1_pin_oe,
        .port1_pullup_en, .port2_pin_in, .port2_pin_out, .port2_pin_oe, .port2_pullup_en,
        .port3_pin_in, .port3_pin_out, .port3_pin_oe, .port3_pullup_en, .timer8_out,
        .timer16_out, .buzzer_out, .ext_irq_rise, .ext_irq_fall, .capture_trigger_in,
        .timer8_clock_in);
    port_board #(.W(8)) board0 (.pin_out(port0_pin_out), .pin_oe(port0_pin_oe),
        .pullup_en(port0_pullup_en), .ext_en(ext0_en), .ext_val(ext0_val), .pin_in(port0_pin_in));
    port_board #(.W(6)) board1 (.pin_out(port1_pin_out), .pin_oe(port1_pin_oe),
        .pullup_en(port1_pullup_en), .ext_en(6'h00), .ext_val(6'h00), .pin_in(port1_pin_in));
    port_board #(.W(8)) board2 (.pin_out(port2_pin_out), .pin_oe(port2_pin_oe),
        .pullup_en(port2_pullup_en), .ext_en(ext2_en), .ext_val(ext2_val), .pin_in(port2_pin_in));
    port_board #(.W(2)) board3 (.pin_out(port3_pin_out), .pin_oe(port3_pin_oe),
        .pullup_en(port3_pullup_en), .ext_en(2'h0), .ext_val(2'h0), .pin_in(port3_pin_in));

    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(logic [15:0] a, logic bit_mode, logic [2:0] sel, logic [7:0] d);
        sfr_addr = a;
        sfr_bit_sel = sel;
        sfr_wdata = d;
        sfr_wr = ~bit_mode;
        sfr_bit_wr = bit_mode;
        @(negedge clock);
        sfr_wr = 1'b0;
        sfr_bit_wr = 1'b0;
        repeat (2) @(negedge clock);
    endtask
    task automatic rdc(string what, logic [15:0] a, logic [7:0] exp);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clock);
        chk(what, exp, sfr_rdata);
        sfr_rd = 1'b0;
        @(negedge clock);
    endtask
    task automatic t_reset();
        for (int i = 0; i < 4; i++) rdc("direction", 16'hff20 + 16'(i), 8'hff);
        rdc("port2 pullup reg", 16'hff32, 8'h00);
        rdc("group pullup reg", 16'hfff7, 8'h00);
        chk("port0 oe", 8'h00, port0_pin_oe);
        $display("done reset");
    endtask
    task automatic t_out();
        wr(16'hff20, 1'b0, 3'h0, 8'h00);
        rdc("port0 latch", 16'hff00, 8'h00);
        wr(16'hff00, 1'b0, 3'h0, 8'ha5);
        chk("port0 out", 8'ha5, port0_pin_out);
        chk("port0 oe", 8'hff, port0_pin_oe);
        rdc("port0 data", 16'hff00, 8'ha5);
        wr(16'hff20, 1'b1, 3'h3, 8'h01);
        rdc("port0 dir", 16'hff20, 8'h08);
        chk("port0 oe", 8'hf7, port0_pin_oe);
        rdc("port0 mixed", 16'hff00, 8'had);
        wr(16'hff00, 1'b1, 3'h0, 8'h00);
        chk("port0 out", 8'ha4, port0_pin_out);
        $display("done output");
    endtask
    task automatic t_pullup();
        wr(16'hfff7, 1'b0, 3'h0, 8'hff);
        rdc("group pullup reg", 16'hfff7, 8'h0b);
        chk("port0 pullup", 8'h08, port0_pullup_en);
        chk("port1 pullup", 8'h3f, {2'b00, port1_pullup_en});
        chk("port2 pullup", 8'h00, port2_pullup_en);
        wr(16'hfff7, 1'b1, 3'h0, 8'h00);
        rdc("group pullup reg", 16'hfff7, 8'h0a);
        chk("port0 pullup", 8'h00, port0_pullup_en);
        wr(16'hff32, 1'b0, 3'h0, 8'h5a);
        wr(16'hff22, 1'b0, 3'h0, 8'h00);
        chk("port2 pullup", 8'h5a, port2_pullup_en);
        $display("done pullup");
    endtask
    task automatic t_reserved();
        wr(16'hff21, 1'b0, 3'h0, 8'h00);
        rdc("port1 dir", 16'hff21, 8'hc0);
        chk("port1 oe", 8'h3f, {2'b00, port1_pin_oe});
        chk("port1 out", 8'h00, {2'b00, port1_pin_out});
        wr(16'hff23, 1'b0, 3'h0, 8'h00);
        wr(16'hff23, 1'b1, 3'h5, 8'h00);
        rdc("port3 dir", 16'hff23, 8'hfc);
        chk("port3 oe", 8'h03, {6'h00, port3_pin_oe});
        wr(16'hfe00, 1'b0, 3'h0, 8'hff);
        rdc("outside window", 16'hfe00, 8'h00);
        chk("hit", 8'h00, {7'h00, sfr_hit});
        rdc("port0 data", 16'hff00, 8'hac);
        chk("hit", 8'h01, {7'h00, sfr_hit});
        timer16_out = 1'b1;
        buzzer_out = 1'b1;
        repeat (2) @(negedge clock);
        chk("port3 alt out", 8'h03, {6'h00, port3_pin_out});
        chk("port3 pullup", 8'h00, {6'h00, port3_pullup_en});
        $display("done reserved");
    endtask
    task automatic t_irq();
        logic [7:0] seen;
        for (int k = 0; k < 3; k++) begin
            seen = 8'h00;
            if (k < 2) begin
                sfr_addr = 16'hff02;
                sfr_wdata = k == 0 ? 8'h10 : 8'h00;
                sfr_wr = 1'b1;
            end else begin
                // A board edge on an input pin must reach the same request path.
                ext2_en = 8'h40;
                timer8_out = 1'b1;
            end
            // The pulse stands one cycle, so every cycle is looked at.
            repeat (6) begin
                @(negedge clock);
                sfr_wr = 1'b0;
                seen = seen | {2'b00, ext_irq_fall, ext_irq_rise};
            end
            chk("irq edges", k == 0 ? 8'h01 : (k == 1 ? 8'h08 : 8'h20), seen);
            @(negedge clock);
            if (k == 1) begin
                wr(16'hff22, 1'b1, 3'h6, 8'h01);
                chk("capture in", 8'h01, {7'h00, capture_trigger_in});
            end
        end
        chk("capture in", 8'h00, {7'h00, capture_trigger_in});
        chk("timer clock in", 8'h01, {7'h00, timer8_clock_in});
        chk("port2 out", 8'h80, port2_pin_out);
        chk("port2 oe", 8'hbf, port2_pin_oe);
        $display("done irq");
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (4) @(negedge clock);
        rst = 1'b0;
        t_reset();
        t_out();
        t_pullup();
        t_reserved();
        t_irq();
        end_sim();
    end
    // The tests need about 100 cycles; twenty times that means a hang.
    initial begin
        repeat (2000) @(posedge clock);
        bad_count++;
        end_sim();
    end
endmodule

`default_nettype wire
